//--- design/tppg_top.v
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "tppg_defines.vh"
module tppg_top (
  input  wire        CLK_SYS,
  input  wire        RST_B,
  input  wire [11:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [11:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire        CNT_TICK,
  input  wire        LOW_FREQ_TICK,
  input  wire        TIMER_INPUT_PIN,
  output reg         PULSE_OUTPUT_PIN,
  output reg         TIMER_IRQ,
  output reg         FILTERED_INPUT
);

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  reg        rst_s1_reg;
  reg        rst_s2_reg;
  wire       rst_b = rst_s2_reg;

  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg  [5:0]  mode_reg;
  reg         run_reg;
  reg         one_shot_reg;
  reg         tff_sel_reg;
  reg         ovf_irq_en_reg;
  reg         dbuf_en_reg;
  reg  [1:0]  nc_sel_reg;
  reg         slow_mode_reg;
  reg  [7:0]  temp_low_reg;
  reg  [15:0] cmpa_buf_reg;
  reg  [15:0] cmpb_buf_reg;
  reg  [15:0] cmpa_act_reg;
  reg  [15:0] cmpb_act_reg;
  reg  [15:0] count_reg;
  reg  [8:0]  nc_div_reg;
  reg  [1:0]  nc_cnt_reg;
  reg         nc_last_reg;

  reg         aw_held_reg;
  reg  [11:0] aw_addr_reg;
  reg         w_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;

  wire        ppg_mode = (mode_reg[2:0] == `TPPG_MODE_PPG);
  wire        match_a  = run_reg && ppg_mode && (count_reg == cmpa_act_reg);
  wire        match_b  = run_reg && ppg_mode && (count_reg == cmpb_act_reg);

  // ------------------------------------------------------------
  // write channel
  // ------------------------------------------------------------
  wire        wr_go   = aw_held_reg && w_held_reg && !S_AXI_BVALID;
  wire        wr_lane = w_strb_reg[0];
  wire [7:0]  wbyte   = w_data_reg[7:0];
  wire        wr_mode = wr_go && wr_lane && (aw_addr_reg == `TPPG_OFF_MODE);
  wire        wr_ctrl = wr_go && wr_lane && (aw_addr_reg == `TPPG_OFF_CTRL);
  wire        wr_al   = wr_go && wr_lane && (aw_addr_reg == `TPPG_OFF_CMPA_L);
  wire        wr_ah   = wr_go && wr_lane && (aw_addr_reg == `TPPG_OFF_CMPA_H);
  wire        wr_bl   = wr_go && wr_lane && (aw_addr_reg == `TPPG_OFF_CMPB_L);
  wire        wr_bh   = wr_go && wr_lane && (aw_addr_reg == `TPPG_OFF_CMPB_H);

  function wr_mapped;
    input [11:0] a;
    begin
      wr_mapped = (a == `TPPG_OFF_MODE) || (a == `TPPG_OFF_CTRL) ||
                  (a == `TPPG_OFF_CMPA_L) || (a == `TPPG_OFF_CMPA_H) ||
                  (a == `TPPG_OFF_CMPB_L) || (a == `TPPG_OFF_CMPB_H) ||
                  (a == `TPPG_OFF_STAT);
    end
  endfunction

  always @(posedge CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_reg   <= 1'b0;
      aw_addr_reg   <= 12'h000;
      w_held_reg    <= 1'b0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `TPPG_RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_held_reg && !S_AXI_AWREADY;
      S_AXI_WREADY  <= !w_held_reg && !S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_reg   <= 1'b1;
        aw_addr_reg   <= {S_AXI_AWADDR[11:2], 2'b00};
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_reg   <= 1'b1;
        w_data_reg   <= S_AXI_WDATA;
        w_strb_reg   <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_go) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_mapped(aw_addr_reg) ? `TPPG_RESP_OKAY : `TPPG_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  always @(posedge CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `TPPG_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY && !S_AXI_ARVALID;
      if (S_AXI_ARVALID && !S_AXI_RVALID && !S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b1;
      end
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RRESP   <= wr_mapped({S_AXI_ARADDR[11:2], 2'b00}) ?
                         `TPPG_RESP_OKAY : `TPPG_RESP_SLVERR;
        // buffer values are read back, not the active compares
        case ({S_AXI_ARADDR[11:2], 2'b00})
          `TPPG_OFF_MODE:   S_AXI_RDATA <= {26'h0, mode_reg};
          `TPPG_OFF_CTRL:   S_AXI_RDATA <= {24'h0, slow_mode_reg, nc_sel_reg, dbuf_en_reg,
                                            ovf_irq_en_reg, tff_sel_reg, one_shot_reg,
                                            run_reg};
          `TPPG_OFF_CMPA_L: S_AXI_RDATA <= {24'h0, cmpa_buf_reg[7:0]};
          `TPPG_OFF_CMPA_H: S_AXI_RDATA <= {24'h0, cmpa_buf_reg[15:8]};
          `TPPG_OFF_CMPB_L: S_AXI_RDATA <= {24'h0, cmpb_buf_reg[7:0]};
          `TPPG_OFF_CMPB_H: S_AXI_RDATA <= {24'h0, cmpb_buf_reg[15:8]};
          `TPPG_OFF_STAT:   S_AXI_RDATA <= {15'h0, PULSE_OUTPUT_PIN, count_reg};
          default:          S_AXI_RDATA <= 32'h0000_0000;
        endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // control, compare registers and counter
  // ------------------------------------------------------------
  always @(posedge CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg       <= 6'h00;
      run_reg        <= 1'b0;
      one_shot_reg   <= 1'b0;
      tff_sel_reg    <= 1'b0;
      ovf_irq_en_reg <= 1'b0;
      dbuf_en_reg    <= 1'b0;
      nc_sel_reg     <= 2'b00;
      slow_mode_reg  <= 1'b0;
      temp_low_reg   <= 8'h00;
      cmpa_buf_reg   <= `TPPG_CMP_RESET;
      cmpb_buf_reg   <= `TPPG_CMP_RESET;
      cmpa_act_reg   <= `TPPG_CMP_RESET;
      cmpb_act_reg   <= `TPPG_CMP_RESET;
      count_reg      <= 16'h0000;
    end else begin
      if (wr_mode && !run_reg) begin
        mode_reg <= wbyte[5:0];
      end
      if (wr_ctrl) begin
        one_shot_reg <= wbyte[`TPPG_CR_ONESHOT];
        dbuf_en_reg  <= wbyte[`TPPG_CR_DBF];
        if (!run_reg) begin
          tff_sel_reg    <= wbyte[`TPPG_CR_TFF];
          ovf_irq_en_reg <= wbyte[`TPPG_CR_OVE];
          nc_sel_reg     <= wbyte[`TPPG_CR_NC_LSB +: 2];
          slow_mode_reg  <= wbyte[`TPPG_CR_SLOW];
        end
      end
      if (wr_al || wr_bl) begin
        temp_low_reg <= wbyte;
      end
      if (wr_ah) begin
        cmpa_buf_reg <= {wbyte, temp_low_reg};
        if (!run_reg || !dbuf_en_reg) begin
          cmpa_act_reg <= {wbyte, temp_low_reg};
        end
      end
      if (wr_bh) begin
        cmpb_buf_reg <= {wbyte, temp_low_reg};
        if (!run_reg || !dbuf_en_reg) begin
          cmpb_act_reg <= {wbyte, temp_low_reg};
        end
      end
      // counting; a compare written below the count wraps through overflow
      if (run_reg && ppg_mode) begin
        if (match_a) begin
          if (dbuf_en_reg) begin
            cmpa_act_reg <= cmpa_buf_reg;
            cmpb_act_reg <= cmpb_buf_reg;
          end
          count_reg <= 16'h0000;
        end else if (CNT_TICK) begin
          count_reg <= count_reg + 16'h0001;
        end
      end else if (!run_reg) begin
        count_reg <= 16'h0000;
      end
      // run bit: software write, one-shot stop wins over it
      if (match_a && one_shot_reg) begin
        run_reg <= 1'b0;
      end else if (wr_ctrl) begin
        run_reg <= wbyte[`TPPG_CR_RUN];
      end
    end
  end

  // ------------------------------------------------------------
  // pulse output and interrupt
  // ------------------------------------------------------------
  always @(posedge CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      PULSE_OUTPUT_PIN <= 1'b0;
      TIMER_IRQ        <= 1'b0;
    end else begin
      TIMER_IRQ <= match_a;
      if (!run_reg || !ppg_mode || match_a) begin
        PULSE_OUTPUT_PIN <= tff_sel_reg;
      end else if (match_b) begin
        PULSE_OUTPUT_PIN <= !tff_sel_reg;
      end
    end
  end

  // ------------------------------------------------------------
  // noise canceller
  // ------------------------------------------------------------
  reg  [8:0] nc_period;
  reg        nc_block;
  always @* begin
    nc_block  = 1'b0;
    nc_period = `TPPG_NC_DIV1;
    case (nc_sel_reg)
      2'b01:   nc_period = `TPPG_NC_DIV1;
      2'b10:   nc_period = `TPPG_NC_DIV2;
      2'b11:   nc_period = slow_mode_reg ? `TPPG_NC_SLOWDIV : `TPPG_NC_DIV3;
      default: nc_period = `TPPG_NC_DIV1;
    endcase
    if (slow_mode_reg && (nc_sel_reg == 2'b01 || nc_sel_reg == 2'b10)) begin
      nc_block = 1'b1;
    end
  end

  // slow mode samples count low-frequency ticks instead of system clocks
  wire nc_step   = slow_mode_reg ? LOW_FREQ_TICK : 1'b1;
  wire nc_sample = nc_step && (nc_div_reg == nc_period - 9'h001);

  always @(posedge CLK_SYS or negedge rst_b) begin
    if (!rst_b) begin
      nc_div_reg     <= 9'h000;
      nc_cnt_reg     <= 2'b00;
      nc_last_reg    <= 1'b0;
      FILTERED_INPUT <= 1'b0;
    end else if (nc_block) begin
      nc_div_reg     <= 9'h000;
      nc_cnt_reg     <= 2'b00;
      FILTERED_INPUT <= 1'b0;
    end else if (nc_sel_reg == 2'b00) begin
      nc_div_reg     <= 9'h000;
      nc_cnt_reg     <= 2'b00;
      FILTERED_INPUT <= TIMER_INPUT_PIN;
    end else if (nc_step) begin
      nc_div_reg <= nc_sample ? 9'h000 : nc_div_reg + 9'h001;
      if (nc_sample) begin
        nc_last_reg <= TIMER_INPUT_PIN;
        if (TIMER_INPUT_PIN != nc_last_reg) begin
          nc_cnt_reg <= 2'b01;
        end else if (nc_cnt_reg != 2'b11) begin
          nc_cnt_reg <= nc_cnt_reg + 2'b01;
        end
        if (TIMER_INPUT_PIN == nc_last_reg && nc_cnt_reg == 2'b10) begin
          FILTERED_INPUT <= TIMER_INPUT_PIN;
        end
      end
    end
  end

endmodule

//--- design/tppg_defines.vh
// Summary of operation
// - mode code 011 selects pulse generation
// - one-shot when select is 1, else continuous
// - flip-flop select sets idle output level
// - run bit starts; mode bits locked while running
// - match B drives output to opposite level
// - match A restores level, raises interrupt
// - one-shot match A clears run bit
// - continuous match A clears counter to zero
// - run bit low returns output to idle
// - one-shot select writable while running
// - double buffer loads compares on match A
// - unbuffered writes act at once, may overflow
// - low byte buffered, high byte commits both
// - buffered read returns last written value
// - stopped writes update buffer and active together
// - filter passes level after three equal samples
// - nonzero filter setting runs regardless of run
// - filter setting writable only while stopped
// - filter intervals 2, 4, 256 gear clocks
// - slow mode: 11 uses low clock/2, 01 and 10 block, 00 passes pin
`ifndef TPPG_DEFINES_VH
`define TPPG_DEFINES_VH
`define TPPG_OFF_MODE   12'h000
`define TPPG_OFF_CTRL   12'h004
`define TPPG_OFF_CMPA_L 12'h008
`define TPPG_OFF_CMPA_H 12'h00c
`define TPPG_OFF_CMPB_L 12'h010
`define TPPG_OFF_CMPB_H 12'h014
`define TPPG_OFF_STAT   12'h018
// mode register fields
`define TPPG_MODE_LSB   0
`define TPPG_CK_LSB     3
`define TPPG_MODE_PPG   3'h3
// control register fields
`define TPPG_CR_RUN     0
`define TPPG_CR_ONESHOT 1
`define TPPG_CR_TFF     2
`define TPPG_CR_OVE     3
`define TPPG_CR_DBF     4
`define TPPG_CR_NC_LSB  5
`define TPPG_CR_SLOW    7
`define TPPG_NC_DIV1    9'h002
`define TPPG_NC_DIV2    9'h004
`define TPPG_NC_DIV3    9'h100
`define TPPG_NC_SLOWDIV 9'h002
`define TPPG_CMP_RESET  16'hffff
`define TPPG_RESP_OKAY  2'b00
`define TPPG_RESP_SLVERR 2'b10
`endif

//--- sim/tppg_checker.sv
`timescale 1ns/1ps
`include "tppg_defines.vh"
module tppg_checker (
  input wire        CLK_SYS,
  input wire        RST_B,
  input wire        S_AXI_AWVALID,
  input wire        S_AXI_AWREADY,
  input wire [1:0]  S_AXI_BRESP,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire [1:0]  S_AXI_RRESP,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire        TIMER_INPUT_PIN,
  input wire        TIMER_IRQ,
  input wire        FILTERED_INPUT
);
  // ------------------------------------------
  // port relations
  // ------------------------------------------
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  property p_irq_pulse; TIMER_IRQ |=> !TIMER_IRQ; endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt wider than one cycle");
  // a stale sample must never reach the timer
  property p_filt; $changed(FILTERED_INPUT) |-> FILTERED_INPUT == $past(TIMER_INPUT_PIN);
  endproperty
  a_filt: assert property (p_filt)
    else $error("filtered level differs from pin");
  property p_b_after_aw; S_AXI_AWVALID && S_AXI_AWREADY |-> ##[1:4] S_AXI_BVALID; endproperty
  a_b_after_aw: assert property (p_b_after_aw)
    else $error("write response late");
  property p_b_done; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
  a_b_done: assert property (p_b_done)
    else $error("write response repeated");
  property p_r_after_ar; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_r_after_ar: assert property (p_r_after_ar)
    else $error("read data late");
  property p_r_done; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
  a_r_done: assert property (p_r_done)
    else $error("read data repeated");
  property p_bresp;
    S_AXI_BVALID |-> S_AXI_BRESP inside {`TPPG_RESP_OKAY, `TPPG_RESP_SLVERR};
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("bad write response code");
  property p_rresp;
    S_AXI_RVALID |-> S_AXI_RRESP inside {`TPPG_RESP_OKAY, `TPPG_RESP_SLVERR};
  endproperty
  a_rresp: assert property (p_rresp)
    else $error("bad read response code");
endmodule

//--- sim/tppg_load.sv
`timescale 1ns/1ps
// ------------------------------------------
// pulse output load: width of the last high phase, in cycles
// ------------------------------------------
module tppg_load (
  input  wire    clk,
  input  wire    pin_level,
  output integer high_len
);
  integer run_len = 0;
  initial high_len = 0;
  always @(posedge clk) begin
    if (pin_level) begin
      run_len <= run_len + 1;
    end else begin
      if (run_len != 0) high_len <= run_len;
      run_len <= 0;
    end
  end
endmodule

//--- sim/tppg_top_tb.sv
`timescale 1ns/1ps
`include "tppg_defines.vh"
module tppg_top_tb;
  localparam [1:0]  okr = `TPPG_RESP_OKAY;
  localparam [11:0] md  = `TPPG_OFF_MODE;
  localparam [11:0] cr  = `TPPG_OFF_CTRL;
  localparam [11:0] ca  = `TPPG_OFF_CMPA_L;
  localparam [11:0] cb  = `TPPG_OFF_CMPB_L;
  reg         clk, rst_b, awvalid, wvalid, bready, arvalid, rready, tin, lft;
  reg  [11:0] awaddr, araddr;
  reg  [31:0] wdata;
  wire        awready, wready, bvalid, arready, rvalid, pout, irq, filt;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     hi, failures, num_checks;
  tppg_top DUT (.CLK_SYS(clk), .RST_B(rst_b), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CNT_TICK(1'b1), .LOW_FREQ_TICK(lft), .TIMER_INPUT_PIN(tin), .PULSE_OUTPUT_PIN(pout),
    .TIMER_IRQ(irq), .FILTERED_INPUT(filt));
  tppg_load u_load (.clk(clk), .pin_level(pout), .high_len(hi));
  // ------------------------------------------
  // helpers
  // ------------------------------------------
  task stop_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task tmo;
    failures = failures + 1;
    stop_test;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    num_checks = num_checks + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one write (w=1) or read; request held until its ready, answer taken at its valid
  task bus(input w, input [11:0] a, input [7:0] d, input [1:0] er);
    integer n;
    @(posedge clk);
    if (w) begin
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    n = 0;
    do begin
      @(posedge clk);
      n = n + 1;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
    end while (!(bvalid || rvalid) && n < 50);
    bready <= 1'b0;
    rready <= 1'b0;
    if (n == 50) tmo;
    if (w) chk(32'(bresp), 32'(er));
    else chk(32'(rresp), 32'(er));
    if (!w && er == okr) chk(32'(rdata[7:0]), 32'(d));
  endtask
  task cw(input [11:0] lo, input [15:0] v);
    bus(1, lo, v[7:0], okr);
    bus(1, lo + 12'h004, v[15:8], okr);
  endtask
  // the limit stays far below a full 16-bit wrap, so an overflow shows as a timeout
  task wirq(output integer t);
    t = 0;
    do begin
      @(posedge clk);
      t = t + 1;
    end while (!irq && t < 3000);
    if (!irq) tmo;
  endtask
  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  task t_regs;
    bus(0, cr, 8'h00, okr);
    bus(1, 12'h100, 8'h00, `TPPG_RESP_SLVERR);
    bus(0, 12'h100, 8'h00, `TPPG_RESP_SLVERR);
    bus(1, ca, 8'h34, okr);
    bus(0, ca, 8'hff, okr);
    bus(1, ca + 12'h004, 8'h12, okr);
    bus(0, ca, 8'h34, okr);
  endtask
  task t_cont;
    integer t;
    cw(ca, 16'd39);
    cw(cb, 16'd4);
    bus(1, md, 8'h03, okr);
    bus(1, cr, 8'h01, okr);
    wirq(t);
    wirq(t);
    chk(t, 40);
    repeat (3) @(posedge clk);
    chk(32'(pout), 0);
    chk(hi, 35);
    repeat (7) @(posedge clk);
    chk(32'(pout), 1);
    bus(1, cr, 8'h65, okr);
    bus(0, cr, 8'h01, okr);
    bus(1, md, 8'h00, okr);
    bus(0, md, 8'h03, okr);
    bus(1, cr, 8'h00, okr);
    repeat (2) @(posedge clk);
    chk(32'(pout), 0);
  endtask
  task t_dbuf;
    integer t;
    bus(1, cr, 8'h11, okr);
    wirq(t);
    cw(ca, 16'd9);
    bus(0, ca, 8'd9, okr);
    wirq(t);
    wirq(t);
    chk(t, 10);
    bus(1, cr, 8'h00, okr);
  endtask
  task t_shot;
    integer t, n;
    bus(1, cr, 8'h04, okr);
    repeat (2) @(posedge clk);
    chk(32'(pout), 1);
    bus(1, cr, 8'h05, okr);
    wirq(t);
    bus(1, cr, 8'h07, okr);
    wirq(t);
    repeat (3) @(posedge clk);
    bus(0, cr, 8'h06, okr);
    chk(32'(pout), 1);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      n = n + irq;
    end
    chk(n, 0);
    bus(1, cr, 8'h03, okr);
    bus(1, cr, 8'h01, okr);
    wirq(t);
    wirq(t);
    bus(1, cr, 8'h00, okr);
  endtask
  task t_filt;
    integer i, iv;
    for (i = 0; i < 4; i = i + 1) begin
      iv = (i == 0) ? 1 : (i == 1) ? 2 : (i == 2) ? 4 : 256;
      bus(1, cr, {1'b0, i[1:0], 5'h00}, okr);
      repeat (4 * iv + 8) @(posedge clk);
      tin <= ~tin;
      repeat (iv) @(posedge clk);
      if (i > 0) chk(32'(filt), 32'(!tin));
      repeat (3 * iv + 8) @(posedge clk);
      chk(32'(filt), 32'(tin));
    end
  endtask
  // slow mode: 01 blocks the pin, 11 samples only on low-frequency ticks
  task t_slow;
    bus(1, cr, 8'ha0, okr);
    tin <= 1'b1;
    repeat (20) @(posedge clk);
    chk(32'(filt), 0);
    bus(1, cr, 8'he0, okr);
    repeat (20) @(posedge clk);
    chk(32'(filt), 0);
    lft <= 1'b1;
    repeat (16) @(posedge clk);
    chk(32'(filt), 1);
    lft <= 1'b0;
    bus(1, cr, 8'h00, okr);
  endtask
  // ------------------------------------------
  // run
  // ------------------------------------------
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, tin, lft} = 0;
    {awaddr, araddr, wdata} = 0;
    failures = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs;
    t_cont;
    t_dbuf;
    t_shot;
    t_filt;
    t_slow;
    stop_test;
  end
endmodule
bind tppg_top tppg_checker u_chk (.CLK_SYS, .RST_B, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RRESP,
  .S_AXI_RVALID, .S_AXI_RREADY, .TIMER_INPUT_PIN, .TIMER_IRQ, .FILTERED_INPUT);
